// >>> psp_pkg.sv
// Package for the parameter-set loader and service port.
// Assumes a single 10 MHz core clock shared by every user of the package.
package psp_pkg;
	// Timing
	localparam int CLK_HZ   = 10_000_000;
	localparam int BAUD     = 9600;
	localparam int BIT_CYC  = (CLK_HZ + BAUD / 2) / BAUD;
	localparam int DEB_US   = 200;
	localparam int DEB_CYC  = (DEB_US * (CLK_HZ / 1_000_000));
	localparam int TEST_US  = 100;
	localparam int TEST_CYC = (TEST_US * (CLK_HZ / 1_000_000));
	// Parameter set layout: words 0..6 data, word 7 checksum
	localparam int SET_WORDS = 8;
	localparam int W_IN_FUNC = 0;
	localparam int W_OUT_FUNC = 1;
	localparam logic [7:0] FN_IN_ZERO  = 8'h00;
	localparam logic [7:0] FN_OUT_ERR  = 8'h00;
	localparam logic [7:0] FN_OUT_RDY  = 8'h01;
	localparam logic [7:0] DEF_SCALE   = 8'h01;
	// Service framing characters
	localparam logic [7:0] CH_STX = 8'h02;
	localparam logic [7:0] CH_CR  = 8'h0d;
	localparam logic [7:0] CH_LF  = 8'h0a;
	localparam logic [3:0] FRAME_LAST = 4'ha;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
	localparam logic [7:0] OFS_SET_BASE = 8'h20;
	// Control command bits
	localparam int C_FACTORY = 0;
	localparam int C_PRESET  = 1;
	localparam int C_SWRESET = 2;
	localparam int C_STORE   = 3;
	localparam int C_SEND    = 4;
	// Interrupt bits
	localparam int IRQ_W       = 5;
	localparam int I_LOADED    = 0;
	localparam int I_DEFAULTS  = 1;
	localparam int I_FRAME_OK  = 2;
	localparam int I_FRAME_BAD = 3;
	localparam int I_TX_DONE   = 4;

	typedef logic [SET_WORDS-1:0][7:0] psp_set_t;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
	} psp_avs_req_s;

	typedef struct packed {
		logic ready;
		logic busy;
		logic service;
		logic nv_valid;
		logic defaults;
		logic tx_busy;
	} psp_status_s;

	function automatic logic [7:0] psp_csum(input psp_set_t s);
		logic [7:0] a;
		a = 8'h00;
		for (int i = 0; i < SET_WORDS - 1; i++) begin
			a = a + s[i];
		end
		return ~a;
	endfunction

	function automatic logic psp_valid(input psp_set_t s);
		return s[SET_WORDS-1] == psp_csum(s);
	endfunction

	function automatic psp_set_t psp_defaults();
		psp_set_t s;
		s = '0;
		s[W_IN_FUNC] = FN_IN_ZERO;
		s[W_OUT_FUNC] = FN_OUT_ERR;
		s[2] = DEF_SCALE;
		s[SET_WORDS-1] = psp_csum(s);
		return s;
	endfunction
endpackage

// >>> psp_top.sv
// Parameter-set manager, service UART and switching I/O of the sensor.
// Assumes core_clk at 10 MHz; strap, switch and serial pins are asynchronous.
// Notes on behaviour
// R01 - Three sets kept: ROM defaults, nonvolatile current set, working copy.
// R02 - A set is loaded only after its checksum is found valid.
// R03 - Defaults load on first start, factory command, or bad current set.
// R04 - Current set loads at power-up and after a software reset.
// R05 - Parameter-reset command overwrites the current set with defaults.
// R06 - Current set changes only from a valid host frame, valid store or parameter-reset command.
// R07 - Service link runs 9600 baud, 8 data bits, no parity, 1 stop.
// R08 - Service frames start with STX and end with CR then LF.
// R09 - Service mode only while the service strap is held low.
// R10 - Flow control by request-to-send only; clear-to-send is ignored.
// R11 - Zero input by default resets the reported position to zero.
// R12 - Error output open normally, closed on a positioning error.
// R13 - Input and output functions chosen by set words, defaults zero/error.
// R14 - Self-test runs after power-up; ready indicator lights afterwards.
// R15 - Strap and switch input are synchronised and debounced before use.
`timescale 1ns/1ps
`default_nettype none
module psp_top (
	input  wire logic                 core_clk,
	input  wire logic                 reset_n,
	input  wire psp_pkg::psp_avs_req_s avs_req,
	output logic [31:0]               avs_readdata,
	output logic                      avs_waitrequest,
	output logic                      irq,
	input  wire logic                 service_sel_n,
	input  wire logic                 position_zero_input,
	input  wire logic [23:0]          position_in,
	input  wire logic                 position_error,
	output logic [23:0]               position_out,
	output logic                      position_error_output,
	output logic                      ready_led,
	input  wire logic                 svc_rxd,
	output logic                      svc_txd,
	output logic                      svc_rts
);
	typedef enum logic [4:0] {
		LD_TEST  = 5'b00001,
		LD_LOAD  = 5'b00010,
		LD_IDLE  = 5'b00100,
		LD_FRAME = 5'b01000,
		LD_STORE = 5'b10000
	} psp_ld_e;
	typedef enum logic [3:0] {
		RX_IDLE  = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA  = 4'b0100,
		RX_STOP  = 4'b1000
	} psp_rx_e;

	localparam psp_pkg::psp_set_t ROM_SET = psp_pkg::psp_defaults(); // R01

	// Input synchronisers: first stage read only by the second
	logic [2:0] s1_q, s2_q;
	always_ff @(posedge core_clk) begin
		s1_q <= {svc_rxd, position_zero_input, service_sel_n};
		s2_q <= s1_q;
	end // R15

	// Debounce of strap and switch input
	logic [1:0]  deb_q, deb_d;
	logic [11:0] dcnt_q [2];
	logic [11:0] dcnt_d [2];
	logic        zero_prev_q;
	for (genvar g = 0; g < 2; g++) begin : g_deb
		always_comb begin
			dcnt_d[g] = 12'h000;
			deb_d[g] = deb_q[g];
			if (s2_q[g] != deb_q[g]) begin
				dcnt_d[g] = dcnt_q[g] + 12'h001;
				if (dcnt_q[g] == 12'(psp_pkg::DEB_CYC - 1)) begin
					deb_d[g] = s2_q[g];
					dcnt_d[g] = 12'h000;
				end
			end
		end // R15
		always_ff @(posedge core_clk) begin
			if (!reset_n) begin
				deb_q[g] <= (g == 0) ? 1'b1 : 1'b0;
				dcnt_q[g] <= 12'h000;
			end else begin
				deb_q[g] <= deb_d[g];
				dcnt_q[g] <= dcnt_d[g];
			end
		end
	end
	wire logic service_mode = !deb_q[0]; // R09

	// Receiver state
	psp_rx_e    rx_st_q, rx_st_d;
	logic [10:0] rx_cnt_q, rx_cnt_d;
	logic [2:0] rx_bit_q, rx_bit_d;
	logic [7:0] rx_sh_q, rx_sh_d;
	logic       rx_strobe;
	// Frame and set state
	psp_ld_e    ld_q, ld_d;
	psp_pkg::psp_set_t work_q, work_d, nv_q, nv_d, stage_q, stage_d;
	logic [9:0] tcnt_q, tcnt_d;
	logic [3:0] fidx_q, fidx_d;
	logic       infr_q, infr_d, cr_q, cr_d;
	logic       rdy_q, rdy_d, dflt_q, dflt_d;
	logic [psp_pkg::IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d, iev;
	// Transmitter
	logic [9:0] tx_sh_q, tx_sh_d;
	logic [3:0] tx_bits_q, tx_bits_d, tx_idx_q, tx_idx_d;
	logic [10:0] tx_cnt_q, tx_cnt_d;
	logic       tx_fr_q, tx_fr_d;
	// Bus
	logic        wait_q, wait_d;
	logic [31:0] rd_q, rd_d;
	logic        acc, wr;
	logic [4:0]  cmd;
	logic [23:0] ofs_q, ofs_d, pos_q, pos_d;
	logic        err_q, err_d;
	logic        zero_d;

	// UART receive, 8N1, sampled mid-bit
	always_comb begin
		rx_st_d = rx_st_q;
		rx_cnt_d = rx_cnt_q + 11'h001;
		rx_bit_d = rx_bit_q;
		rx_sh_d = rx_sh_q;
		rx_strobe = 1'b0;
		case (rx_st_q)
			RX_IDLE: begin
				rx_cnt_d = 11'h000;
				if (!s2_q[2] && service_mode) begin
					rx_st_d = RX_START;
				end
			end
			RX_START: begin
				if (rx_cnt_q == 11'(psp_pkg::BIT_CYC / 2)) begin
					rx_cnt_d = 11'h000;
					rx_bit_d = 3'h0;
					rx_st_d = s2_q[2] ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				if (rx_cnt_q == 11'(psp_pkg::BIT_CYC - 1)) begin
					rx_cnt_d = 11'h000;
					rx_sh_d = {s2_q[2], rx_sh_q[7:1]};
					rx_bit_d = rx_bit_q + 3'h1;
					if (rx_bit_q == 3'h7) begin
						rx_st_d = RX_STOP;
					end
				end
			end // R07
			RX_STOP: begin
				if (rx_cnt_q == 11'(psp_pkg::BIT_CYC - 1)) begin
					rx_strobe = s2_q[2];
					rx_st_d = RX_IDLE;
				end
			end
			default: rx_st_d = RX_IDLE;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			rx_st_q <= RX_IDLE;
			rx_cnt_q <= 11'h000;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
		end else begin
			rx_st_q <= rx_st_d;
			rx_cnt_q <= rx_cnt_d;
			rx_bit_q <= rx_bit_d;
			rx_sh_q <= rx_sh_d;
		end
	end

	// Bus decode helpers
	assign acc = (avs_req.read || avs_req.write) && !wait_q;
	assign wr = acc && avs_req.write;
	assign cmd = (wr && avs_req.address == psp_pkg::OFS_CTRL) ? avs_req.writedata[4:0] : 5'h00;

	// Loader, set memories, frame parser and interrupt status
	always_comb begin
		ld_d = ld_q;
		work_d = work_q;
		nv_d = nv_q;
		stage_d = stage_q;
		tcnt_d = tcnt_q;
		fidx_d = fidx_q;
		infr_d = infr_q;
		cr_d = cr_q;
		rdy_d = rdy_q;
		dflt_d = dflt_q;
		iev = '0;
		if (rx_strobe) begin
			if (rx_sh_q == psp_pkg::CH_STX) begin
				infr_d = 1'b1;
				fidx_d = 4'h0;
				cr_d = 1'b0;
			end else if (infr_q && cr_q && rx_sh_q == psp_pkg::CH_LF) begin
				infr_d = 1'b0;
				if (fidx_q == 4'(psp_pkg::SET_WORDS) && psp_pkg::psp_valid(stage_q)) begin
					ld_d = LD_FRAME;
				end else begin
					iev[psp_pkg::I_FRAME_BAD] = 1'b1;
				end
			end else if (infr_q) begin
				cr_d = (rx_sh_q == psp_pkg::CH_CR);
				if (rx_sh_q != psp_pkg::CH_CR && fidx_q < 4'(psp_pkg::SET_WORDS)) begin
					stage_d[fidx_q[2:0]] = rx_sh_q;
					fidx_d = fidx_q + 4'h1;
				end
			end
		end // R08
		case (ld_q)
			LD_TEST: begin
				tcnt_d = tcnt_q + 10'h001;
				if (tcnt_q == 10'(psp_pkg::TEST_CYC - 1) && psp_pkg::psp_valid(ROM_SET)) begin
					ld_d = LD_LOAD;
				end
			end // R14
			LD_LOAD: begin
				if (psp_pkg::psp_valid(nv_q)) begin
					work_d = nv_q;
					dflt_d = 1'b0;
				end else begin
					work_d = ROM_SET;
					dflt_d = 1'b1;
					iev[psp_pkg::I_DEFAULTS] = 1'b1;
				end // R02 R03 R04
				iev[psp_pkg::I_LOADED] = 1'b1;
				rdy_d = 1'b1; // R14
				ld_d = LD_IDLE;
			end
			LD_FRAME: begin
				nv_d = stage_q; // R06
				work_d = stage_q;
				dflt_d = 1'b0;
				iev[psp_pkg::I_FRAME_OK] = 1'b1;
				ld_d = LD_IDLE;
			end
			LD_STORE: begin
				if (psp_pkg::psp_valid(work_q)) begin
					nv_d = work_q; // R06
				end
				ld_d = LD_IDLE;
			end
			default: begin
				if (cmd[psp_pkg::C_FACTORY]) begin
					work_d = ROM_SET; // R03
					dflt_d = 1'b1;
					iev[psp_pkg::I_DEFAULTS] = 1'b1;
				end else if (cmd[psp_pkg::C_PRESET]) begin
					nv_d = ROM_SET; // R05
				end else if (cmd[psp_pkg::C_SWRESET]) begin
					ld_d = LD_LOAD; // R04
				end else if (cmd[psp_pkg::C_STORE]) begin
					ld_d = LD_STORE;
				end else if (wr && avs_req.address[7:5] == psp_pkg::OFS_SET_BASE[7:5]) begin
					work_d[avs_req.address[4:2]] = avs_req.writedata[7:0];
				end
			end
		endcase
		if (!service_mode) begin
			infr_d = 1'b0;
		end
		if (tx_fr_q && tx_idx_q == psp_pkg::FRAME_LAST && tx_bits_q == 4'h0 && tx_cnt_q == 11'h000) begin
			iev[psp_pkg::I_TX_DONE] = 1'b1;
		end
		ist_d = ist_q;
		if (wr && avs_req.address == psp_pkg::OFS_IRQ_STAT) begin
			ist_d = ist_q & ~avs_req.writedata[psp_pkg::IRQ_W-1:0];
		end
		ist_d = ist_d | iev;
		imask_d = imask_q;
		if (wr && avs_req.address == psp_pkg::OFS_IRQ_MASK) begin
			imask_d = avs_req.writedata[psp_pkg::IRQ_W-1:0];
		end
	end
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			ld_q <= LD_TEST;
			work_q <= '0;
			nv_q <= '0;
			stage_q <= '0;
			tcnt_q <= 10'h000;
			fidx_q <= 4'h0;
			infr_q <= 1'b0;
			cr_q <= 1'b0;
			rdy_q <= 1'b0;
			dflt_q <= 1'b0;
			ist_q <= '0;
			imask_q <= '0;
		end else begin
			ld_q <= ld_d;
			work_q <= work_d;
			nv_q <= nv_d;
			stage_q <= stage_d;
			tcnt_q <= tcnt_d;
			fidx_q <= fidx_d;
			infr_q <= infr_d;
			cr_q <= cr_d;
			rdy_q <= rdy_d;
			dflt_q <= dflt_d;
			ist_q <= ist_d;
			imask_q <= imask_d;
		end
	end

	// Transmitter: sends STX, working set, CR, LF on request
	always_comb begin
		tx_sh_d = tx_sh_q;
		tx_bits_d = tx_bits_q;
		tx_idx_d = tx_idx_q;
		tx_cnt_d = tx_cnt_q;
		tx_fr_d = tx_fr_q;
		if (tx_bits_q != 4'h0) begin
			tx_cnt_d = tx_cnt_q + 11'h001;
			if (tx_cnt_q == 11'(psp_pkg::BIT_CYC - 1)) begin
				tx_cnt_d = 11'h000;
				tx_sh_d = {1'b1, tx_sh_q[9:1]};
				tx_bits_d = tx_bits_q - 4'h1;
			end
		end else if (tx_fr_q && tx_idx_q != psp_pkg::FRAME_LAST) begin
			tx_idx_d = tx_idx_q + 4'h1;
			tx_bits_d = 4'ha;
			if (tx_idx_q < 4'(psp_pkg::SET_WORDS)) begin
				tx_sh_d = {1'b1, work_q[tx_idx_q[2:0]], 1'b0};
			end else if (tx_idx_q == 4'(psp_pkg::SET_WORDS)) begin
				tx_sh_d = {1'b1, psp_pkg::CH_CR, 1'b0};
			end else begin
				tx_sh_d = {1'b1, psp_pkg::CH_LF, 1'b0};
			end // R07 R08
		end else if (tx_fr_q) begin
			tx_fr_d = 1'b0;
		end else if (cmd[psp_pkg::C_SEND] && service_mode) begin
			tx_fr_d = 1'b1;
			tx_idx_d = 4'h0;
			tx_bits_d = 4'ha;
			tx_sh_d = {1'b1, psp_pkg::CH_STX, 1'b0}; // R08
		end
	end
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			tx_sh_q <= 10'h3ff;
			tx_bits_q <= 4'h0;
			tx_idx_q <= 4'h0;
			tx_cnt_q <= 11'h000;
			tx_fr_q <= 1'b0;
		end else begin
			tx_sh_q <= tx_sh_d;
			tx_bits_q <= tx_bits_d;
			tx_idx_q <= tx_idx_d;
			tx_cnt_q <= tx_cnt_d;
			tx_fr_q <= tx_fr_d;
		end
	end

	// Avalon slave: one wait state, read data registered
	psp_pkg::psp_status_s st;
	always_comb begin
		st = '{rdy_q, ld_q != LD_IDLE, service_mode, psp_pkg::psp_valid(nv_q), dflt_q, tx_fr_q};
		wait_d = !((avs_req.read || avs_req.write) && wait_q);
		rd_d = 32'h0000_0000;
		if (avs_req.address == psp_pkg::OFS_STATUS) begin
			rd_d = {26'h0, st};
		end else if (avs_req.address == psp_pkg::OFS_IRQ_STAT) begin
			rd_d = {27'h0, ist_q};
		end else if (avs_req.address == psp_pkg::OFS_IRQ_MASK) begin
			rd_d = {27'h0, imask_q};
		end else if (avs_req.address[7:5] == psp_pkg::OFS_SET_BASE[7:5]) begin
			rd_d = {24'h0, work_q[avs_req.address[4:2]]};
		end
	end
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			wait_q <= 1'b1;
			rd_q <= 32'h0000_0000;
		end else begin
			wait_q <= wait_d;
			rd_q <= rd_d;
		end
	end

	// Position zeroing and switching output by configured function
	always_comb begin
		ofs_d = ofs_q;
		zero_d = deb_q[1];
		if (deb_q[1] && !zero_prev_q && work_q[psp_pkg::W_IN_FUNC] == psp_pkg::FN_IN_ZERO) begin
			ofs_d = position_in; // R11 R13
		end
		pos_d = position_in - ofs_q;
		if (work_q[psp_pkg::W_OUT_FUNC] == psp_pkg::FN_OUT_ERR) begin
			err_d = position_error && rdy_q; // R12 R13
		end else if (work_q[psp_pkg::W_OUT_FUNC] == psp_pkg::FN_OUT_RDY) begin
			err_d = rdy_q;
		end else begin
			err_d = 1'b0;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			ofs_q <= 24'h000000;
			pos_q <= 24'h000000;
			err_q <= 1'b0;
			zero_prev_q <= 1'b0;
		end else begin
			ofs_q <= ofs_d;
			pos_q <= pos_d;
			err_q <= err_d;
			zero_prev_q <= zero_d;
		end
	end

	// Outputs straight from flip-flops
	logic irq_q, rts_q;
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			irq_q <= 1'b0;
			rts_q <= 1'b0;
		end else begin
			irq_q <= |(ist_d & imask_d);
			rts_q <= service_mode && ld_d == LD_IDLE; // R10
		end
	end
	assign avs_readdata = rd_q;
	assign avs_waitrequest = wait_q;
	assign irq = irq_q;
	assign position_out = pos_q;
	assign position_error_output = err_q;
	assign ready_led = rdy_q;
	assign svc_txd = tx_sh_q[0];
	assign svc_rts = rts_q;
endmodule // psp_top
`default_nettype wire

// >>> psp_sva.sv
// Concurrent checks on the ports of the parameter-set and service-port block.
// Assumes psp_top ports and the default switching functions in the working set.
`timescale 1ns/1ps
`default_nettype none
module psp_sva (
	input wire logic                  core_clk,
	input wire logic                  reset_n,
	input wire psp_pkg::psp_avs_req_s avs_req,
	input wire logic [31:0]           avs_readdata,
	input wire logic                  avs_waitrequest,
	input wire logic                  irq,
	input wire logic                  service_sel_n,
	input wire logic                  position_zero_input,
	input wire logic [23:0]           position_in,
	input wire logic                  position_error,
	input wire logic [23:0]           position_out,
	input wire logic                  position_error_output,
	input wire logic                  ready_led,
	input wire logic                  svc_rxd,
	input wire logic                  svc_txd,
	input wire logic                  svc_rts
);
	int unsigned up_q;
	int unsigned run_q;
	int unsigned low_q;
	logic        prev_q;
	logic        strap_q;
	logic        zero_q;

	// Cycle counters and history flags
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			up_q <= 0;
			run_q <= 0;
			low_q <= 0;
			prev_q <= 1'b1;
			strap_q <= 1'b0;
			zero_q <= 1'b0;
		end else begin
			up_q <= (up_q < 100000) ? up_q + 1 : up_q;
			run_q <= (svc_txd != prev_q) ? 1 : run_q + 1;
			low_q <= service_sel_n ? 0 : low_q + 1;
			prev_q <= svc_txd;
			strap_q <= strap_q | !service_sel_n;
			zero_q <= zero_q | position_zero_input;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	bit_time_a: assert property (svc_txd && !prev_q |-> run_q % psp_pkg::BIT_CYC == 0)
		else $error("serial low run not whole bit times");
	line_idle_a: assert property (!strap_q |-> svc_txd && !svc_rts)
		else $error("service line active without strap");
	rts_deb_a: assert property ($rose(svc_rts) |-> low_q >= psp_pkg::DEB_CYC)
		else $error("request-to-send before strap debounce");
	ready_time_a: assert property (ready_led |-> up_q >= psp_pkg::TEST_CYC)
		else $error("ready lit before self test time");
	rst_vals_a: assert property (disable iff (1'b0) !reset_n |=> !ready_led && !irq && svc_txd && !svc_rts && avs_waitrequest)
		else $error("outputs not at reset values");
	err_close_a: assert property ((ready_led && position_error)[*3] |-> position_error_output)
		else $error("error output not closed");
	err_open_a: assert property ((!position_error)[*3] |-> !position_error_output)
		else $error("error output closed without error");
	pos_track_a: assert property (!zero_q && $past(reset_n) |-> position_out == $past(position_in))
		else $error("position output does not follow input");
endmodule // psp_sva

bind psp_top psp_sva psp_sva_i (.core_clk, .reset_n, .avs_req, .avs_readdata, .avs_waitrequest, .irq,
	.service_sel_n, .position_zero_input, .position_in, .position_error, .position_out,
	.position_error_output, .ready_led, .svc_rxd, .svc_txd, .svc_rts);
`default_nettype wire

// >>> psp_term.sv
// Behavioural terminal on the service serial link.
// Assumes the 10 MHz core clock; the line idles high between characters.
`timescale 1ns/1ps
`default_nettype none
module psp_term (
	input wire logic core_clk,
	input wire logic svc_txd,
	input wire logic svc_rts,
	output var logic svc_rxd
);
	// Line rests at mark level
	initial svc_rxd = 1'b1;

	// Send one 8N1 character once request-to-send is high
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		while (svc_rts !== 1'b1) @(posedge core_clk);
		for (int i = 0; i < 10; i++) begin
			svc_rxd <= f[i];
			repeat (psp_pkg::BIT_CYC) @(posedge core_clk);
		end
	endtask

	// Take one character, data in bits 7..0 and stop bit in bit 8
	task automatic recv(output logic [8:0] r);
		while (svc_txd !== 1'b0) @(posedge core_clk);
		repeat (psp_pkg::BIT_CYC / 2) @(posedge core_clk);
		for (int i = 0; i < 9; i++) begin
			repeat (psp_pkg::BIT_CYC) @(posedge core_clk);
			r[i] = svc_txd;
		end
	endtask
endmodule // psp_term
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the parameter-set and service-port block.
// Assumes psp_top, psp_term and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic                  core_clk = 1'b0;
	logic                  reset_n = 1'b0;
	psp_pkg::psp_avs_req_s avs_req = '0;
	logic [31:0]           avs_readdata;
	logic [23:0]           position_in = 24'h000000;
	logic [23:0]           position_out;
	logic                  service_sel_n = 1'b1;
	logic                  position_zero_input = 1'b0;
	logic                  position_error = 1'b0;
	logic                  avs_waitrequest, irq, position_error_output, ready_led, svc_rxd, svc_txd, svc_rts;
	int                    failures = 0;
	int                    n_tests = 0;
	int                    cyc_n = 0;

	// Clock and units
	always #50 core_clk = ~core_clk;
	psp_top psp_top_i (.core_clk, .reset_n, .avs_req, .avs_readdata, .avs_waitrequest, .irq, .service_sel_n,
		.position_zero_input, .position_in, .position_error, .position_out, .position_error_output,
		.ready_led, .svc_rxd, .svc_txd, .svc_rts);
	psp_term psp_term_i (.core_clk, .svc_txd, .svc_rts, .svc_rxd);

	task automatic tally_and_finish;
		$display("failures=%0d n_tests=%0d", failures, n_tests);
		if (failures == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// Hang guard
	always @(posedge core_clk) begin
		cyc_n++;
		if (cyc_n == 90000) begin
			failures++;
			tally_and_finish();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		avs_req <= '{read: !wr, write: wr, address: a, writedata: d};
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_req <= '0;
		@(posedge core_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q & m, e);
	endtask

	// Poll until the loader is idle
	task automatic idle;
		logic [31:0] q;
		do bus(1'b0, 8'h04, 32'h0, q); while (q[4] !== 1'b0);
	endtask

	task automatic t_boot;
		int n;
		n = 0;
		while (ready_led !== 1'b1) begin
			@(posedge core_clk);
			n++;
		end
		chk(32'(n >= 1000 && n <= 1100), 32'h1);
		rd(8'h04, 32'hffffffff, 32'h22);
		for (int i = 0; i < 8; i++) begin
			rd(8'h20 + 8'(4 * i), 32'hffffffff, (i == 2) ? 32'h01 : (i == 7) ? 32'hfe : 32'h00);
		end
		rd(8'h08, 32'h02, 32'h02);
	endtask

	task automatic t_irq;
		rd(8'h10, 32'hffffffff, 32'h0);
		rd(8'h00, 32'hffffffff, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(8'h0c, 32'h02);
		rd(8'h0c, 32'hffffffff, 32'h02);
		chk({31'h0, irq}, 32'h1);
		wr(8'h08, 32'h1f);
		rd(8'h08, 32'hffffffff, 32'h0);
		chk({31'h0, irq}, 32'h0);
	endtask

	task automatic t_sets;
		wr(8'h28, 32'h05);
		wr(8'h3c, 32'hfa);
		wr(8'h00, 32'h08);
		idle();
		rd(8'h04, 32'h04, 32'h04);
		wr(8'h28, 32'h09);
		wr(8'h00, 32'h04);
		idle();
		rd(8'h28, 32'hff, 32'h05);
		wr(8'h00, 32'h01);
		idle();
		rd(8'h28, 32'hff, 32'h01);
		wr(8'h00, 32'h02);
		idle();
		wr(8'h28, 32'h07);
		wr(8'h00, 32'h08);
		idle();
		wr(8'h00, 32'h04);
		idle();
		rd(8'h28, 32'hff, 32'h01);
	endtask

	task automatic t_zero;
		position_in <= 24'h123456;
		cyc(3);
		chk({8'h0, position_out}, 32'h123456);
		position_zero_input <= 1'b1;
		cyc(100);
		position_zero_input <= 1'b0;
		cyc(2500);
		chk({8'h0, position_out}, 32'h123456);
		position_zero_input <= 1'b1;
		cyc(2500);
		chk({8'h0, position_out}, 32'h0);
		position_zero_input <= 1'b0;
		position_in <= 24'h123461;
		cyc(3);
		chk({8'h0, position_out}, 32'h0b);
		wr(8'h20, 32'h01);
		cyc(2500);
		position_zero_input <= 1'b1;
		cyc(2500);
		chk({8'h0, position_out}, 32'h0b);
		position_zero_input <= 1'b0;
		wr(8'h20, 32'h00);
	endtask

	task automatic t_err;
		chk({31'h0, position_error_output}, 32'h0);
		position_error <= 1'b1;
		cyc(3);
		chk({31'h0, position_error_output}, 32'h1);
		position_error <= 1'b0;
		cyc(3);
		chk({31'h0, position_error_output}, 32'h0);
	endtask

	task automatic t_svc;
		logic [8:0] r;
		chk({31'h0, svc_rts}, 32'h0);
		service_sel_n <= 1'b0;
		cyc(1000);
		chk({31'h0, svc_rts}, 32'h0);
		cyc(1500);
		chk({31'h0, svc_rts}, 32'h1);
		rd(8'h04, 32'h08, 32'h08);
		wr(8'h0c, 32'h08);
		psp_term_i.send(psp_pkg::CH_STX);
		psp_term_i.send(psp_pkg::CH_CR);
		psp_term_i.send(psp_pkg::CH_LF);
		cyc(10);
		rd(8'h08, 32'h0c, 32'h08);
		chk({31'h0, irq}, 32'h1);
		wr(8'h08, 32'h08);
		wr(8'h00, 32'h10);
		psp_term_i.recv(r);
		chk({23'h0, r}, {23'h0, 1'b1, psp_pkg::CH_STX});
	endtask

	// Main sequence
	initial begin
		cyc(20);
		reset_n <= 1'b1;
		t_boot();
		t_irq();
		t_sets();
		t_zero();
		t_err();
		t_svc();
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
